// ===== hdl/vsr_field_detect.sv
// Per-field detection flags for caption, widescreen and teletext slicer hits
`timescale 1ns/1ps
`default_nettype none
module vsr_field_detect
	import vsr_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Field timing
	input wire logic fieldStart,
	input wire logic fieldOdd,
	// Slicer hits: 0 caption, 1 widescreen, 2 teletext
	input wire logic [2:0] sliceHit,
	// Flags in register order: caption odd, caption even, widescreen odd, widescreen even, teletext
	output logic [4:0] detFlags
);

	logic [2:0] seen_q;
	logic curOdd_q;

	// Hits gather over the running field; a hit on the start cycle belongs to the new field
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			seen_q <= 3'h0;
			curOdd_q <= 1'b0;
		end else if (fieldStart) begin
			seen_q <= sliceHit;
			curOdd_q <= fieldOdd;
		end else begin
			seen_q <= seen_q | sliceHit;
		end
	end

	// Caption and widescreen keep one flag per parity; flops stay local so the output has one driver
	wire [1:0] oddFlag;
	wire [1:0] evenFlag;
	logic ttxFlag_q;

	genvar k;
	generate
		for (k = 0; k < 2; k++) begin : g_par
			logic odd_q;
			logic even_q;
			always_ff @(posedge core_clk or negedge rstn) begin
				if (!rstn) begin
					odd_q <= 1'b0;
					even_q <= 1'b0;
				end else if (fieldStart) begin
					if (curOdd_q) begin
						odd_q <= seen_q[k];
					end else begin
						even_q <= seen_q[k];
					end
				end
			end
			assign oddFlag[k] = odd_q;
			assign evenFlag[k] = even_q;
		end
	endgenerate

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ttxFlag_q <= 1'b0;
		end else if (fieldStart) begin
			ttxFlag_q <= seen_q[2];
		end
	end

	assign detFlags = {oddFlag[0], evenFlag[0], oddFlag[1], evenFlag[1], ttxFlag_q};

	property p_caption_odd_commit;
		@(posedge core_clk) disable iff (!rstn)
		(fieldStart && curOdd_q) |=> (detFlags[4] == $past(seen_q[0]));
	endproperty
	a_caption_odd_commit: assert property (p_caption_odd_commit) else $error("odd caption flag not committed");

	property p_even_keeps_odd;
		@(posedge core_clk) disable iff (!rstn)
		(fieldStart && !curOdd_q) |=> $stable(detFlags[4]) && $stable(detFlags[2]);
	endproperty
	a_even_keeps_odd: assert property (p_even_keeps_odd) else $error("even field touched odd flags");

endmodule
`default_nettype wire

// ===== hdl/vsr_pkg.sv
// Package of offsets, field layouts, reset values and states for the vertical-blank status register group
package vsr_pkg;

	// ----------------------------------------------------------------
	// Register sub-addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_SLICE_EN = 8'h0A;
	localparam logic [7:0] REG_OUT_EN = 8'h0B;
	localparam logic [7:0] REG_DETECT = 8'h0C;
	localparam logic [7:0] REG_VID_STAT = 8'h0E;
	localparam logic [7:0] REG_IRQ_MASK = 8'h0F;
	localparam logic [7:0] REG_IRQ_STAT = 8'h10;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int OUT_CAPTION_BIT = 7;
	localparam int OUT_WIDESCREEN_BIT = 6;
	localparam int OUT_TTX_BIT = 5;
	localparam int OUT_REALTIME_BIT = 0;
	localparam int CP_IRQ_BIT = 2;

	// Writable bits; reserved bits stay zero
	localparam logic [7:0] OUT_WR_MASK = 8'hE1;
	localparam logic [7:0] SLICE_WR_MASK = 8'hFC;
	localparam logic [7:0] CP_IRQ_MASK = 8'h04;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_SLICE_EN = 8'h00;
	localparam logic [7:0] RST_OUT_EN = 8'h00;
	localparam logic [7:0] RST_VID_STAT = 8'h00;
	localparam logic [4:0] RST_DETECT = 5'h00;
	localparam logic [2:0] RST_CP_CODE = 3'h0;

	// ----------------------------------------------------------------
	// Serial control engine states
	// ----------------------------------------------------------------
	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_ADDR = 9'h002,
		ST_ACKA = 9'h004,
		ST_SUB = 9'h008,
		ST_ACKS = 9'h010,
		ST_WR = 9'h020,
		ST_ACKW = 9'h040,
		ST_RD = 9'h080,
		ST_RACK = 9'h100
	} vsr_state_t;

endpackage

// ===== hdl/vsr_regs.sv
// Vertical-blank data output enables and video status registers behind the serial control port
`timescale 1ns/1ps
`default_nettype none
module vsr_regs
	import vsr_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h44
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Serial control pins (open drain)
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOeN,
	// Decoder state
	input wire logic vLock,
	input wire logic hLock,
	input wire logic chromaLock,
	input wire logic videoPresent,
	input wire logic [2:0] copyProtCode,
	input wire logic stdDetected,
	input wire logic autoDetectEn,
	// Field timing and slicer hits
	input wire logic fieldStart,
	input wire logic fieldOdd,
	input wire logic captionTextHit,
	input wire logic widescreenSignalHit,
	input wire logic teletextHit,
	// Slicer configuration
	output logic [1:0] captionSliceMode,
	output logic [1:0] widescreenSliceMode,
	output logic [1:0] ttxSystem,
	// Ancillary insertion enables
	output logic ancCaptionOddEn,
	output logic ancCaptionEvenEn,
	output logic ancWidescreenOddEn,
	output logic ancWidescreenEvenEn,
	output logic ancTtxEn,
	output logic ancRealtimeEn,
	// Copy protection change request
	output logic copyProtIrq
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic sclS;
	logic sdaS;

	vsr_sync3 #(.RST_VAL(1'b1)) u_scl_sync (
		.core_clk(core_clk),
		.rstn(rstn),
		.pinIn(sclIn),
		.levelOut(sclS)
	);

	vsr_sync3 #(.RST_VAL(1'b1)) u_sda_sync (
		.core_clk(core_clk),
		.rstn(rstn),
		.pinIn(sdaIn),
		.levelOut(sdaS)
	);

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [7:0] sliceEn_q;
	logic [7:0] outEn_q;
	logic [7:0] vidStat_q;
	logic [2:0] cpPrev_q;
	logic irqMask_q;
	logic irqStat_q;
	logic [4:0] detFlags;

	vsr_field_detect u_detect (
		.core_clk(core_clk),
		.rstn(rstn),
		.fieldStart(fieldStart),
		.fieldOdd(fieldOdd),
		.sliceHit({teletextHit, widescreenSignalHit, captionTextHit}),
		.detFlags(detFlags)
	);

	// Caption and widescreen data registers live elsewhere; their reads never
	// consult outEn_q, so readout stays available whatever the enables say.
	// Teletext has no sub-address here and decodes to zero.
	function automatic logic [7:0] regRead(input logic [7:0] a);
		case (a)
			REG_SLICE_EN: regRead = sliceEn_q;
			REG_OUT_EN: regRead = outEn_q;
			REG_DETECT: regRead = {detFlags, 3'h0};
			REG_VID_STAT: regRead = vidStat_q;
			REG_IRQ_MASK: regRead = {5'h00, irqMask_q, 2'h0};
			REG_IRQ_STAT: regRead = {5'h00, irqStat_q, 2'h0};
			default: regRead = 8'h00;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Serial control engine
	// ----------------------------------------------------------------
	vsr_state_t st_q;
	logic sclPrev_q;
	logic sdaPrev_q;
	logic [7:0] shift_q;
	logic [7:0] rdByte_q;
	logic [7:0] sub_q;
	logic [3:0] bitCnt_q;
	logic isRead_q;
	logic ackSeen_q;
	logic sdaLow_q;
	logic sclRise;
	logic sclFall;
	logic busStart;
	logic busStop;
	logic byteDone;
	logic wrEn;
	logic [7:0] rdNext;

	assign sclRise = sclS && !sclPrev_q;
	assign sclFall = !sclS && sclPrev_q;
	assign busStart = sclS && sclPrev_q && sdaPrev_q && !sdaS;
	assign busStop = sclS && sclPrev_q && !sdaPrev_q && sdaS;
	assign byteDone = sclFall && (bitCnt_q == 4'h8);
	assign wrEn = (st_q == ST_WR) && byteDone;
	assign rdNext = regRead(sub_q);

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			sclPrev_q <= 1'b1;
			sdaPrev_q <= 1'b1;
		end else begin
			sclPrev_q <= sclS;
			sdaPrev_q <= sdaS;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= ST_IDLE;
			shift_q <= 8'h00;
			rdByte_q <= 8'h00;
			sub_q <= 8'h00;
			bitCnt_q <= 4'h0;
			isRead_q <= 1'b0;
			ackSeen_q <= 1'b0;
			sdaLow_q <= 1'b0;
		end else if (busStart) begin
			st_q <= ST_ADDR;
			bitCnt_q <= 4'h0;
			sdaLow_q <= 1'b0;
		end else if (busStop) begin
			st_q <= ST_IDLE;
			sdaLow_q <= 1'b0;
		end else begin
			case (st_q)
				ST_ADDR, ST_SUB, ST_WR: begin
					if (sclRise) begin
						shift_q <= {shift_q[6:0], sdaS};
						bitCnt_q <= bitCnt_q + 4'h1;
					end else if (byteDone) begin
						bitCnt_q <= 4'h0;
						if (st_q == ST_ADDR) begin
							if (shift_q[7:1] == DEV_ADDR) begin
								sdaLow_q <= 1'b1;
								isRead_q <= shift_q[0];
								st_q <= ST_ACKA;
							end else begin
								st_q <= ST_IDLE;
							end
						end else if (st_q == ST_SUB) begin
							sub_q <= shift_q;
							sdaLow_q <= 1'b1;
							st_q <= ST_ACKS;
						end else begin
							// Auto-increment so bursts walk the map
							sub_q <= sub_q + 8'h01;
							sdaLow_q <= 1'b1;
							st_q <= ST_ACKW;
						end
					end
				end
				ST_ACKA, ST_RACK: begin
					if (sclRise) begin
						ackSeen_q <= !sdaS;
					end else if (sclFall) begin
						if (st_q == ST_ACKA && !isRead_q) begin
							sdaLow_q <= 1'b0;
							st_q <= ST_SUB;
						end else if (st_q == ST_ACKA || ackSeen_q) begin
							sdaLow_q <= !rdNext[7];
							rdByte_q <= {rdNext[6:0], 1'b0};
							bitCnt_q <= 4'h1;
							st_q <= ST_RD;
						end else begin
							sdaLow_q <= 1'b0;
							st_q <= ST_IDLE;
						end
					end
				end
				ST_ACKS, ST_ACKW: begin
					if (sclFall) begin
						sdaLow_q <= 1'b0;
						st_q <= ST_WR;
					end
				end
				ST_RD: begin
					if (byteDone) begin
						sdaLow_q <= 1'b0;
						sub_q <= sub_q + 8'h01;
						bitCnt_q <= 4'h0;
						st_q <= ST_RACK;
					end else if (sclFall) begin
						sdaLow_q <= !rdByte_q[7];
						rdByte_q <= {rdByte_q[6:0], 1'b0};
						bitCnt_q <= bitCnt_q + 4'h1;
					end
				end
				ST_IDLE: begin
					sdaLow_q <= 1'b0;
				end
				default: begin
					st_q <= ST_IDLE;
					sdaLow_q <= 1'b0;
				end
			endcase
		end
	end

	// Open drain: only ever pull low
	assign sdaOut = 1'b0;
	assign sdaOeN = !sdaLow_q;

	// ----------------------------------------------------------------
	// Writable registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			sliceEn_q <= RST_SLICE_EN;
		end else if (wrEn && sub_q == REG_SLICE_EN) begin
			sliceEn_q <= shift_q & SLICE_WR_MASK;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			outEn_q <= RST_OUT_EN;
		end else if (wrEn && sub_q == REG_OUT_EN) begin
			outEn_q <= shift_q & OUT_WR_MASK;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			irqMask_q <= 1'b0;
		end else if (wrEn && sub_q == REG_IRQ_MASK) begin
			irqMask_q <= shift_q[CP_IRQ_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Status capture; writes to REG_DETECT and REG_VID_STAT have no target
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			vidStat_q <= RST_VID_STAT;
		end else begin
			vidStat_q[7] <= vLock;
			vidStat_q[6] <= hLock;
			vidStat_q[5] <= chromaLock;
			vidStat_q[4] <= videoPresent;
			vidStat_q[3:1] <= copyProtCode;
			vidStat_q[0] <= autoDetectEn && stdDetected;
		end
	end

	// Set beats clear so a change landing on the clearing write is kept
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cpPrev_q <= RST_CP_CODE;
			irqStat_q <= 1'b0;
		end else begin
			cpPrev_q <= vidStat_q[3:1];
			if (vidStat_q[3:1] != cpPrev_q) begin
				irqStat_q <= 1'b1;
			end else if (wrEn && sub_q == REG_IRQ_STAT && shift_q[CP_IRQ_BIT]) begin
				irqStat_q <= 1'b0;
			end
		end
	end

	assign copyProtIrq = irqStat_q && irqMask_q;

	// ----------------------------------------------------------------
	// Slicer and ancillary controls
	// ----------------------------------------------------------------
	assign captionSliceMode = sliceEn_q[7:6];
	assign widescreenSliceMode = sliceEn_q[5:4];
	assign ttxSystem = sliceEn_q[3:2];
	assign ancCaptionOddEn = outEn_q[OUT_CAPTION_BIT] && sliceEn_q[6];
	assign ancCaptionEvenEn = outEn_q[OUT_CAPTION_BIT] && sliceEn_q[7];
	assign ancWidescreenOddEn = outEn_q[OUT_WIDESCREEN_BIT] && sliceEn_q[4];
	assign ancWidescreenEvenEn = outEn_q[OUT_WIDESCREEN_BIT] && sliceEn_q[5];
	assign ancTtxEn = outEn_q[OUT_TTX_BIT];
	assign ancRealtimeEn = outEn_q[OUT_REALTIME_BIT];

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_caption_needs_slice;
		@(posedge core_clk) disable iff (!rstn)
		(wrEn && sub_q == REG_SLICE_EN && shift_q[7:6] == 2'b00) |=> !ancCaptionOddEn && !ancCaptionEvenEn;
	endproperty
	a_caption_needs_slice: assert property (p_caption_needs_slice) else $error("caption output without slicing");

	property p_caption_out_write;
		@(posedge core_clk) disable iff (!rstn)
		(wrEn && sub_q == REG_OUT_EN) |=> (ancCaptionOddEn == ($past(shift_q[7]) && sliceEn_q[6]));
	endproperty
	a_caption_out_write: assert property (p_caption_out_write) else $error("caption output enable wrong");

	property p_widescreen_out_write;
		@(posedge core_clk) disable iff (!rstn)
		(wrEn && sub_q == REG_OUT_EN) |=> (ancWidescreenEvenEn == ($past(shift_q[6]) && sliceEn_q[5]));
	endproperty
	a_widescreen_out_write: assert property (p_widescreen_out_write) else $error("widescreen output enable wrong");

	property p_ttx_out_write;
		@(posedge core_clk) disable iff (!rstn)
		(wrEn && sub_q == REG_OUT_EN) |=> (ancTtxEn == $past(shift_q[5]));
	endproperty
	a_ttx_out_write: assert property (p_ttx_out_write) else $error("teletext output enable wrong");

	property p_realtime_reserved;
		@(posedge core_clk) disable iff (!rstn)
		(wrEn && sub_q == REG_OUT_EN) |=> (ancRealtimeEn == $past(shift_q[0])) && (outEn_q[4:1] == 4'h0);
	endproperty
	a_realtime_reserved: assert property (p_realtime_reserved) else $error("realtime enable or reserved bits wrong");

	property p_detect_low_zero;
		@(posedge core_clk) disable iff (!rstn)
		(st_q == ST_RD && sub_q == REG_DETECT) |-> (rdNext[2:0] == 3'h0);
	endproperty
	a_detect_low_zero: assert property (p_detect_low_zero) else $error("detect reserved bits not zero");

	property p_locks_follow;
		@(posedge core_clk) disable iff (!rstn)
		##1 (vidStat_q[7:4] == $past({vLock, hLock, chromaLock, videoPresent}));
	endproperty
	a_locks_follow: assert property (p_locks_follow) else $error("lock status does not track decoder");

	property p_std_gated;
		@(posedge core_clk) disable iff (!rstn)
		!autoDetectEn |=> !vidStat_q[0];
	endproperty
	a_std_gated: assert property (p_std_gated) else $error("standard flag set with auto-detect off");

	property p_cp_change_irq;
		@(posedge core_clk) disable iff (!rstn)
		(vidStat_q[3:1] != cpPrev_q) |=> irqStat_q ##0 (copyProtIrq == irqMask_q);
	endproperty
	a_cp_change_irq: assert property (p_cp_change_irq) else $error("copy protection change lost");

	property p_status_ro;
		@(posedge core_clk) disable iff (!rstn)
		(wrEn && sub_q == REG_VID_STAT) |=> (vidStat_q[3:1] == $past(copyProtCode));
	endproperty
	a_status_ro: assert property (p_status_ro) else $error("status register took written value");

endmodule
`default_nettype wire

// ===== hdl/vsr_sync3.sv
// Three-stage synchroniser for a pin input; output follows once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module vsr_sync3 #(
	parameter logic RST_VAL = 1'b1
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Pin and filtered level
	input wire logic pinIn,
	output logic levelOut
);

	logic s1_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
		end else begin
			s1_q <= pinIn;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// A level counts only once two stages agree, filtering single-cycle glitches
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			levelOut <= RST_VAL;
		end else if (s2_q == s3_q) begin
			levelOut <= s3_q;
		end
	end

endmodule
`default_nettype wire

// ===== sim/vsr_host_model.sv
// Serial control bus host that drives the clock and open-drain data pins of the register block
`timescale 1ns/1ps
`default_nettype none
module vsr_host_model #(
	parameter logic [6:0] DEV_ADDR = 7'h44
) (
	// Clock
	input wire logic core_clk,
	// Device side of the data line
	input wire logic sdaOut,
	input wire logic sdaOeN,
	// Pin levels seen by the device
	output logic sclIn,
	output logic sdaIn
);
	logic sclHigh;
	logic sdaLow;
	logic [6:0] devSel;

	// Pull-up: a released line reads high, never the last driven value
	assign sclIn = sclHigh;
	assign sdaIn = ~sdaLow & (sdaOeN | sdaOut);

	initial begin
		sclHigh = 1'b1;
		sdaLow = 1'b0;
		devSel = DEV_ADDR;
	end

	// ----------------------------------------------------------------
	// Bit and byte level
	// ----------------------------------------------------------------
	// Each clock phase is at least 5 core cycles, above the 2-cycle filter minimum
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task automatic put_bit(input logic b);
		tick(1);
		sdaLow <= ~b;
		tick(5);
		sclHigh <= 1'b1;
		tick(5);
		sclHigh <= 1'b0;
	endtask

	task automatic get_bit(output logic b);
		tick(1);
		sdaLow <= 1'b0;
		tick(5);
		sclHigh <= 1'b1;
		tick(5);
		b = sdaIn;
		sclHigh <= 1'b0;
	endtask

	// Works as first or repeated start; the wait lets the device drop its acknowledge
	task automatic start_cond();
		tick(5);
		sdaLow <= 1'b0;
		tick(5);
		sclHigh <= 1'b1;
		tick(5);
		sdaLow <= 1'b1;
		tick(5);
		sclHigh <= 1'b0;
	endtask

	task automatic stop_cond();
		tick(1);
		sdaLow <= 1'b1;
		tick(5);
		sclHigh <= 1'b1;
		tick(5);
		sdaLow <= 1'b0;
		tick(5);
	endtask

	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			put_bit(d[i]);
		end
		get_bit(a);
		ack = ~a;
	endtask

	task automatic recv_byte(input logic last, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			get_bit(d[i]);
		end
		put_bit(last);
	endtask

	// ----------------------------------------------------------------
	// Transfers
	// ----------------------------------------------------------------
	task automatic address_phase(input logic [7:0] sub, output logic ack);
		logic a1;
		logic a2;
		start_cond();
		send_byte({devSel, 1'b0}, a1);
		send_byte(sub, a2);
		ack = a1 & a2;
	endtask

	task automatic write_reg(input logic [7:0] sub, input logic [7:0] d, output logic ack);
		logic a0;
		logic a1;
		address_phase(sub, a0);
		send_byte(d, a1);
		stop_cond();
		ack = a0 & a1;
	endtask

	task automatic write_pair(input logic [7:0] sub, input logic [15:0] d, output logic ack);
		logic a0;
		logic a1;
		logic a2;
		address_phase(sub, a0);
		send_byte(d[15:8], a1);
		send_byte(d[7:0], a2);
		stop_cond();
		ack = a0 & a1 & a2;
	endtask

	task automatic read_reg(input logic [7:0] sub, output logic [7:0] d, output logic ack);
		logic a0;
		logic a1;
		address_phase(sub, a0);
		start_cond();
		send_byte({devSel, 1'b1}, a1);
		recv_byte(1'b1, d);
		stop_cond();
		ack = a0 & a1;
	endtask
endmodule
`default_nettype wire

// ===== sim/vsr_regs_tb.sv
// Self-checking testbench for the vertical-blank data output enable and video status registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
	checks++; \
	if ((got) !== (exp)) begin \
		mismatches++; \
		$display("CHECK FAILED at %0t: got %h expected %h", $time, (got), (exp)); \
	end \
end
module vsr_regs_tb
	import vsr_pkg::*;
;
	localparam logic [6:0] DEV = 7'h44;
	logic core_clk, rstn, sclIn, sdaIn, sdaOut, sdaOeN;
	logic vLock, hLock, chromaLock, videoPresent, stdDetected, autoDetectEn;
	logic fieldStart, fieldOdd, captionTextHit, widescreenSignalHit, teletextHit, copyProtIrq;
	logic [2:0] copyProtCode;
	logic [1:0] captionSliceMode, widescreenSliceMode, ttxSystem;
	wire [5:0] anc;
	logic [7:0] rd;
	logic ack;
	int mismatches = 0;
	int checks = 0;

	vsr_regs #(.DEV_ADDR(DEV)) u_dut (.core_clk(core_clk), .rstn(rstn), .sclIn(sclIn), .sdaIn(sdaIn),
		.sdaOut(sdaOut), .sdaOeN(sdaOeN), .vLock(vLock), .hLock(hLock), .chromaLock(chromaLock),
		.videoPresent(videoPresent), .copyProtCode(copyProtCode), .stdDetected(stdDetected),
		.autoDetectEn(autoDetectEn), .fieldStart(fieldStart), .fieldOdd(fieldOdd),
		.captionTextHit(captionTextHit), .widescreenSignalHit(widescreenSignalHit),
		.teletextHit(teletextHit), .captionSliceMode(captionSliceMode),
		.widescreenSliceMode(widescreenSliceMode), .ttxSystem(ttxSystem), .ancCaptionOddEn(anc[5]),
		.ancCaptionEvenEn(anc[4]), .ancWidescreenOddEn(anc[3]), .ancWidescreenEvenEn(anc[2]),
		.ancTtxEn(anc[1]), .ancRealtimeEn(anc[0]), .copyProtIrq(copyProtIrq));

	vsr_host_model #(.DEV_ADDR(DEV)) u_host (.core_clk(core_clk), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
		.sclIn(sclIn), .sdaIn(sdaIn));

	// ----------------------------------------------------------------
	// Access and report tasks
	// ----------------------------------------------------------------
	task automatic wr(input logic [7:0] sub, input logic [7:0] d);
		u_host.write_reg(sub, d, ack);
		`CHK(ack, 1'b1)
	endtask

	task automatic rd_chk(input logic [7:0] sub, input logic [7:0] exp);
		u_host.read_reg(sub, rd, ack);
		`CHK(rd, exp)
	endtask

	// Hits land mid-field, clear of the field-start cycle
	task automatic field(input logic odd, input logic [2:0] hits);
		@(posedge core_clk);
		fieldStart <= 1'b1;
		fieldOdd <= odd;
		@(posedge core_clk);
		fieldStart <= 1'b0;
		repeat (3) @(posedge core_clk);
		{teletextHit, widescreenSignalHit, captionTextHit} <= hits;
		@(posedge core_clk);
		{teletextHit, widescreenSignalHit, captionTextHit} <= 3'b000;
		repeat (3) @(posedge core_clk);
	endtask

	task automatic test_done(input string name);
		$display("Test %s finished, mismatches so far %0d", name, mismatches);
	endtask

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Clock and watchdog
	// ----------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// The sequence needs about 17k cycles; 60k leaves ample margin
	initial begin
		#(60000 * 20);
		mismatches++;
		$display("Watchdog expired");
		print_verdict();
	end

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		rstn = 1'b0;
		{vLock, hLock, chromaLock, videoPresent, stdDetected, autoDetectEn} = 6'h00;
		{fieldStart, fieldOdd, captionTextHit, widescreenSignalHit, teletextHit} = 5'h00;
		copyProtCode = 3'h0;
		repeat (4) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (6) @(posedge core_clk);
		`CHK({anc, copyProtIrq, captionSliceMode}, 9'h000)
		rd_chk(REG_OUT_EN, 8'h00);
		rd_chk(REG_SLICE_EN, 8'h00);
		rd_chk(REG_DETECT, 8'h00);
		rd_chk(REG_VID_STAT, 8'h00);
		test_done("reset");

		wr(REG_OUT_EN, 8'hFF);
		rd_chk(REG_OUT_EN, 8'hE1);
		`CHK(anc, 6'b000011)
		for (logic [2:0] m = 0; m < 4; m++) begin
			wr(REG_SLICE_EN, {m[1:0], m[1:0], 4'hF});
			rd_chk(REG_SLICE_EN, {m[1:0], m[1:0], 4'hC});
			`CHK({captionSliceMode, widescreenSliceMode, ttxSystem}, {m[1:0], m[1:0], 2'b11})
			`CHK(anc, {m[0], m[1], m[0], m[1], 2'b11})
		end
		u_host.write_pair(REG_SLICE_EN, 16'hD740, ack);
		`CHK(ack, 1'b1)
		rd_chk(REG_SLICE_EN, 8'hD4);
		rd_chk(REG_OUT_EN, 8'h40);
		`CHK(anc, 6'b001000)
		test_done("output enables");

		wr(REG_DETECT, 8'hFF);
		wr(REG_VID_STAT, 8'hFF);
		rd_chk(REG_DETECT, 8'h00);
		rd_chk(REG_VID_STAT, 8'h00);
		wr(8'h20, 8'hFF);
		rd_chk(8'h20, 8'h00);
		u_host.devSel = DEV + 7'h01;
		u_host.write_reg(REG_OUT_EN, 8'h01, ack);
		`CHK(ack, 1'b0)
		u_host.devSel = DEV;
		rd_chk(REG_OUT_EN, 8'h40);
		test_done("read-only");

		for (logic [3:0] c = 0; c < 8; c++) begin
			@(posedge core_clk);
			copyProtCode <= c[2:0];
			{vLock, hLock, chromaLock, videoPresent} <= {c[0], c[1], c[2], ~c[0]};
			stdDetected <= c[2];
			autoDetectEn <= c[1];
			rd_chk(REG_VID_STAT, {c[0], c[1], c[2], ~c[0], c[2:0], c[1] & c[2]});
		end
		test_done("video status");

		rd_chk(REG_IRQ_STAT, 8'h04);
		`CHK(copyProtIrq, 1'b0)
		wr(REG_IRQ_MASK, 8'h04);
		`CHK(copyProtIrq, 1'b1)
		wr(REG_IRQ_STAT, 8'h04);
		rd_chk(REG_IRQ_STAT, 8'h00);
		`CHK(copyProtIrq, 1'b0)
		@(posedge core_clk);
		copyProtCode <= 3'b010;
		repeat (4) @(posedge core_clk);
		`CHK(copyProtIrq, 1'b1)
		test_done("copy protection request");

		wr(REG_OUT_EN, 8'h00);
		field(1'b1, 3'b101);
		field(1'b0, 3'b010);
		field(1'b1, 3'b000);
		rd_chk(REG_DETECT, 8'h90);
		field(1'b0, 3'b100);
		field(1'b1, 3'b000);
		rd_chk(REG_DETECT, 8'h08);
		rd_chk(8'h0D, 8'h00);
		test_done("field detect");
		print_verdict();
	end
endmodule
`default_nettype wire
